//--- dtc_adc_model.sv
`timescale 1ns/10ps
module dtc_adc_model (
  input  wire logic        pclk,
  input  wire logic        adc_active,
  input  wire logic        adc_remote_sel,
  input  wire logic [10:0] local_val,
  input  wire logic [10:0] remote_val,
  output      logic [10:0] local_sample,
  output      logic [10:0] remote_sample
);
  // ****************************************
  // converter results
  // ****************************************
  logic [10:0] junk_r = 11'h000;
  always @(posedge pclk)
    junk_r <= junk_r + 11'h2A5;
  assign local_sample  = (adc_active && !adc_remote_sel) ? local_val : junk_r;
  assign remote_sample = (adc_active && adc_remote_sel) ? remote_val : ~junk_r;
endmodule

//--- dtc_conv_ctl.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
// How it works
// R1: each alarm output is active while a measured temperature exceeds its own threshold.
// R2: sequences start either at the programmed rate or once per one-shot command.
// R3: extended 11-bit results at 0.125 C steps only for 4 Hz or slower and for one-shot.
// R4: legacy 8-bit results at 1 C steps are used at the 8 Hz and 16 Hz rates.
// R5: legacy integration lasts 60 ms per channel, so a sequence lasts about twice that.
// R6: every sequence measures the local then the remote channel and both results are published together.
// R7: with halt at 0 the block free-runs, and a one-shot also starts a sequence.
// R8: the busy status bit is high exactly while a sequence runs.
// R9: previous results stay readable and unchanged while a sequence runs.
// R10: configuration bit 5 selects the remote sensor type, set by the host.
// R11: each active-low alarm pin is pulled low only while hot and released otherwise.
// R12: halt at 1 stops automatic conversions and keeps stored data.
// R13: a one-shot runs in software standby but is ignored in hardware standby.
// R14: entering standby mid-sequence aborts it and leaves results untouched.
// R15: a finished sequence updates both results and clears busy in one cycle.
module dtc_conv_ctl #(
  parameter int INTEG_CYCLES    = dtc_pkg::INTEG_CYC,
  parameter int PERIOD16_CYCLES = dtc_pkg::PERIOD16_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  output      logic        irq,
  input  wire logic        hw_standby_n,
  input  wire logic [10:0] local_sample,
  input  wire logic [10:0] remote_sample,
  output      logic        adc_remote_sel,
  output      logic        adc_remote_type,
  output      logic        adc_active,
  output      logic        overtemp_alarm_one_n_o,
  output      logic        overtemp_alarm_one_n_oe,
  output      logic        overtemp_alarm_two_n_o,
  output      logic        overtemp_alarm_two_n_oe
);
  // ****************************************
  // declarations
  // ****************************************
  localparam int TW = dtc_pkg::TEMP_W;
  localparam int IRQ_W = dtc_pkg::IRQ_W;
  dtc_pkg::dtc_state_t state_r, state_nxt;
  logic [31:0]   tmr_r, rate_cnt_r;
  logic [7:0]    cfg_r, thr_one_r, thr_two_r;
  logic [2:0]    rate_r;
  logic [2:0]    irq_stat_r, irq_mask_r;
  logic [TW-1:0] local_r, remote_r, local_hold_r;
  logic          ext_r, os_pend_r, halt_q_r, a1_r, a2_r;
  logic          hw_standby_n_s1_r, hw_standby_n_s2_r;
  logic [31:0]   prdata_r;
  logic          pslverr_r;
  // ****************************************
  // decode
  // ****************************************
  wire acc      = psel & penable & pce;
  wire wr       = acc & pwrite;
  wire rd_stat  = acc & ~pwrite & (paddr == dtc_pkg::IRQ_STAT_OFF);
  wire wr_cfg   = wr & (paddr == dtc_pkg::CFG_OFF);
  wire wr_rate  = wr & (paddr == dtc_pkg::RATE_OFF);
  wire wr_os    = wr & (paddr == dtc_pkg::ONESHOT_OFF);
  wire wr_mask  = wr & (paddr == dtc_pkg::IRQ_MASK_OFF);
  wire wr_thr1  = wr & (paddr == dtc_pkg::THR_ONE_OFF);
  wire wr_thr2  = wr & (paddr == dtc_pkg::THR_TWO_OFF);
  wire mapped   = (paddr[1:0] == 2'h0) & (paddr <= dtc_pkg::THR_TWO_OFF);
  wire halt     = cfg_r[dtc_pkg::CFG_HALT_BIT];
  wire hw_hw_standby_n  = ~hw_standby_n_s2_r;
  // R8 busy while running
  wire busy     = (state_r != dtc_pkg::ST_IDLE);
  wire integ_end = busy & (tmr_r == 32'h0);
  wire abort    = busy & (hw_hw_standby_n | (halt & ~halt_q_r));
  // R12 halt stops auto
  wire auto_go  = ~halt & ~hw_hw_standby_n & (rate_cnt_r == 32'h0);
  wire start    = ~busy & pce & (auto_go | os_pend_r);
  wire done     = pce & (state_r == dtc_pkg::ST_REMOTE) & integ_end & ~abort;
  // R3 extended only slow or single
  wire ext_sel  = os_pend_r | (rate_r <= dtc_pkg::RATE_EXT_MAX);
  wire [31:0] integ_len = ext_r ? 32'(INTEG_CYCLES * 2) : 32'(INTEG_CYCLES);
  wire [31:0] period = 32'(PERIOD16_CYCLES)
                       << (dtc_pkg::RATE_16HZ - rate_r);
  // R4 legacy drops fraction
  wire [TW-1:0] frac_mask = ext_r ? {TW{1'b1}}
                            : {{(TW-dtc_pkg::FRAC_W){1'b1}},
                               {dtc_pkg::FRAC_W{1'b0}}};
  wire signed [7:0] loc_int = local_r[TW-1:dtc_pkg::FRAC_W];
  wire signed [7:0] rem_int = remote_r[TW-1:dtc_pkg::FRAC_W];
  // R1 compare against thresholds
  wire hot1 = (rem_int > $signed(thr_one_r)) | (loc_int > $signed(thr_one_r));
  wire hot2 = (rem_int > $signed(thr_two_r)) | (loc_int > $signed(thr_two_r));
  wire [IRQ_W-1:0] irq_ev = {hot2 & ~a2_r, hot1 & ~a1_r, done};
  wire [31:0] rd_mux =
    (paddr == dtc_pkg::CFG_OFF)      ? {24'h0, cfg_r} :
    (paddr == dtc_pkg::RATE_OFF)     ? {29'h0, rate_r} :
    (paddr == dtc_pkg::STATUS_OFF)   ? {31'h0, busy} :
    (paddr == dtc_pkg::IRQ_STAT_OFF) ? {29'h0, irq_stat_r} :
    (paddr == dtc_pkg::IRQ_MASK_OFF) ? {29'h0, irq_mask_r} :
    (paddr == dtc_pkg::LOCAL_OFF)    ? {21'h0, local_r} :
    (paddr == dtc_pkg::REMOTE_OFF)   ? {21'h0, remote_r} :
    (paddr == dtc_pkg::THR_ONE_OFF)  ? {24'h0, thr_one_r} :
    (paddr == dtc_pkg::THR_TWO_OFF)  ? {24'h0, thr_two_r} : 32'h0;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign pready  = pce;
  assign irq     = |(irq_stat_r & irq_mask_r);
  // R10 sensor type to front end
  assign adc_remote_type = cfg_r[dtc_pkg::CFG_RTYPE_BIT];
  // R6 local first then remote
  assign adc_remote_sel  = (state_r == dtc_pkg::ST_REMOTE);
  assign adc_active      = busy;
  // R11 open drain drive
  assign overtemp_alarm_one_n_o  = 1'b0;
  assign overtemp_alarm_one_n_oe = a1_r;
  assign overtemp_alarm_two_n_o  = 1'b0;
  assign overtemp_alarm_two_n_oe = a2_r;
  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      dtc_pkg::ST_IDLE:
        if (start)
          state_nxt = dtc_pkg::ST_LOCAL;
      dtc_pkg::ST_LOCAL:
        if (abort)
          state_nxt = dtc_pkg::ST_IDLE;
        else if (integ_end)
          state_nxt = dtc_pkg::ST_REMOTE;
      dtc_pkg::ST_REMOTE:
        if (abort | integ_end)
          state_nxt = dtc_pkg::ST_IDLE;
      default:
        state_nxt = dtc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hw_standby_n_s1_r <= 1'b1;
      hw_standby_n_s2_r <= 1'b1;
    end
    else if (pce)
    begin
      hw_standby_n_s1_r <= hw_standby_n;
      hw_standby_n_s2_r <= hw_standby_n_s1_r;
    end
  end

  // R2 R7 sequencing and timers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r    <= dtc_pkg::ST_IDLE;
      tmr_r      <= 32'h0;
      rate_cnt_r <= 32'h0;
      ext_r      <= 1'b0;
      halt_q_r   <= 1'b0;
    end
    else if (pce)
    begin
      state_r  <= state_nxt;
      halt_q_r <= halt;
      // R5 integration per channel
      if (start | (integ_end & state_r == dtc_pkg::ST_LOCAL))
        tmr_r <= (start ? (ext_sel ? 32'(INTEG_CYCLES * 2)
                                   : 32'(INTEG_CYCLES)) : integ_len) - 32'h1;
      else if (busy & tmr_r != 32'h0)
        tmr_r <= tmr_r - 32'h1;
      if (start)
        rate_cnt_r <= period - 32'h1;
      else if (rate_cnt_r != 32'h0)
        rate_cnt_r <= rate_cnt_r - 32'h1;
      if (start)
        ext_r <= ext_sel;
    end
  end

  // R13 one-shot pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      os_pend_r <= 1'b0;
    else if (pce)
      os_pend_r <= ~hw_hw_standby_n & ((wr_os & ~busy) | (os_pend_r & ~start));
  end

  // R9 R14 R15 results update
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      local_hold_r <= '0;
      local_r      <= '0;
      remote_r     <= '0;
    end
    else if (pce)
    begin
      if (state_r == dtc_pkg::ST_LOCAL & integ_end & ~abort)
        local_hold_r <= local_sample & frac_mask;
      if (done)
      begin
        local_r  <= local_hold_r;
        remote_r <= remote_sample & frac_mask;
      end
    end
  end

  // ****************************************
  // registers, alarms and interrupts
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_r      <= 8'h00;
      rate_r     <= dtc_pkg::RATE_RST;
      thr_one_r  <= dtc_pkg::THR_RST;
      thr_two_r  <= dtc_pkg::THR_RST;
      irq_mask_r <= '0;
      irq_stat_r <= '0;
      a1_r       <= 1'b0;
      a2_r       <= 1'b0;
      prdata_r   <= 32'h0;
      pslverr_r  <= 1'b0;
    end
    else if (pce)
    begin
      if (wr_cfg)
        cfg_r <= pwdata[7:0];
      if (wr_rate)
        rate_r <= (pwdata[2:0] > dtc_pkg::RATE_16HZ) ? dtc_pkg::RATE_16HZ
                                                      : pwdata[2:0];
      if (wr_thr1)
        thr_one_r <= pwdata[7:0];
      if (wr_thr2)
        thr_two_r <= pwdata[7:0];
      if (wr_mask)
        irq_mask_r <= pwdata[IRQ_W-1:0];
      // set wins over read clear
      irq_stat_r <= (rd_stat ? '0 : irq_stat_r) | irq_ev;
      a1_r <= hot1;
      a2_r <= hot2;
      if (psel & ~penable)
      begin
        prdata_r  <= pwrite ? 32'h0 : rd_mux;
        pslverr_r <= ~mapped;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_start;
    pce & start;
  endsequence
  sequence s_local_run;
    state_r == dtc_pkg::ST_LOCAL;
  endsequence

  a_busy_on_start: assert property (@(posedge pclk) disable iff (!presetn) // R8
    s_start |=> busy & (adc_remote_sel == 1'b0)) else $error("busy not set");
  a_local_first: assert property (@(posedge pclk) disable iff (!presetn) // R6
    s_start |=> s_local_run) else $error("sequence not local first");
  a_done_clears: assert property (@(posedge pclk) disable iff (!presetn) // R15
    done |=> ~busy & (local_r == $past(local_hold_r)))
    else $error("done did not update");
  a_results_held: assert property (@(posedge pclk) disable iff (!presetn) // R9
    busy & ~done |=> $stable(local_r) & $stable(remote_r))
    else $error("results changed mid sequence");
  a_standby_abort: assert property (@(posedge pclk) disable iff (!presetn) // R14
    pce & busy & hw_hw_standby_n |=> ~busy & $stable(remote_r))
    else $error("standby did not abort");
  a_oneshot_hwstby: assert property (@(posedge pclk) disable iff (!presetn) // R13
    pce & wr_os & hw_hw_standby_n & ~busy |=> ~os_pend_r)
    else $error("one-shot taken in standby");
  a_halt_idle: assert property (@(posedge pclk) disable iff (!presetn) // R12
    pce & ~busy & halt & ~os_pend_r |=> ~busy) else $error("halt ignored");
  a_fast_legacy: assert property (@(posedge pclk) disable iff (!presetn) // R4
    pce & start & ~os_pend_r & (rate_r > dtc_pkg::RATE_EXT_MAX) |=> ~ext_r)
    else $error("extended at fast rate");
  a_alarm_one: assert property (@(posedge pclk) disable iff (!presetn) // R1
    pce & hot1 ##1 pce |-> overtemp_alarm_one_n_oe)
    else $error("alarm one not driven");
  a_alarm_two: assert property (@(posedge pclk) disable iff (!presetn) // R11
    pce & ~hot2 |=> ~overtemp_alarm_two_n_oe)
    else $error("alarm two not released");
  a_oneshot_ext: assert property (@(posedge pclk) disable iff (!presetn) // R3
    pce & start & os_pend_r |=> ext_r) else $error("one-shot not extended");
  a_remote_next: assert property (@(posedge pclk) disable iff (!presetn) // R6
    pce & (state_r == dtc_pkg::ST_LOCAL) & integ_end & ~abort
    |=> adc_remote_sel) else $error("remote not measured");
endmodule

//--- dtc_pkg.sv
package dtc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] CFG_OFF      = 8'h00;
  localparam logic [7:0] RATE_OFF     = 8'h04;
  localparam logic [7:0] ONESHOT_OFF  = 8'h08;
  localparam logic [7:0] STATUS_OFF   = 8'h0C;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h14;
  localparam logic [7:0] LOCAL_OFF    = 8'h18;
  localparam logic [7:0] REMOTE_OFF   = 8'h1C;
  localparam logic [7:0] THR_ONE_OFF  = 8'h20;
  localparam logic [7:0] THR_TWO_OFF  = 8'h24;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int          CFG_HALT_BIT  = 6;
  localparam int          CFG_RTYPE_BIT = 5;
  localparam int          TEMP_W        = 11;
  localparam int          FRAC_W        = 3;
  localparam int          RATE_W        = 3;
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_DONE_BIT  = 0;
  localparam int          IRQ_A1_BIT    = 1;
  localparam int          IRQ_A2_BIT    = 2;
  localparam logic [2:0]  RATE_RST      = 3'h2;
  localparam logic [2:0]  RATE_16HZ     = 3'h4;
  localparam logic [2:0]  RATE_EXT_MAX  = 3'h2;
  localparam logic [7:0]  THR_RST       = 8'h55;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ      = 50;
  localparam int INTEG_MS     = 60;
  localparam int PERIOD16_US  = 62500;
  localparam int INTEG_CYC    = INTEG_MS * 1000 * CLK_MHZ;
  localparam int PERIOD16_CYC = PERIOD16_US * CLK_MHZ;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_LOCAL, ST_REMOTE} dtc_state_t;
endpackage

//--- test_dual_channel_temp_conversion_ctl.sv
`timescale 1ns/10ps
module test_dual_channel_temp_conversion_ctl;
  // ****************************************
  // stimulus and checking
  // ****************************************
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        hw_standby_n = 1'b1;
  logic        pce     = 1'b1;
  logic [10:0] lv = 11'h000, rv = 11'h000, old, ls, rs;
  logic [31:0] prdata;
  logic        pready, pslverr, irq, rsel, rtype, act, a1o, a1e, a2o, a2e;
  logic [31:0] exp_q[$];
  logic        err_q[$];
  integer      fail_count = 0, num_checks = 0, seed = 16063;
  integer      cur = 0, last = 0, i;

  dtc_conv_ctl #(.INTEG_CYCLES(20), .PERIOD16_CYCLES(50)) DUT (
    .pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .hw_standby_n(hw_standby_n), .local_sample(ls), .remote_sample(rs),
    .adc_remote_sel(rsel), .adc_remote_type(rtype), .adc_active(act),
    .overtemp_alarm_one_n_o(a1o), .overtemp_alarm_one_n_oe(a1e),
    .overtemp_alarm_two_n_o(a2o), .overtemp_alarm_two_n_oe(a2e));

  dtc_adc_model adc (
    .pclk(pclk), .adc_active(act), .adc_remote_sel(rsel),
    .local_val(lv), .remote_val(rv),
    .local_sample(ls), .remote_sample(rs));

  initial
  begin
    forever #10 pclk = ~pclk;
  end

  task test_done;
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask

  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      test_done;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic er = 1'b0);
    exp_q.push_back(e);
    err_q.push_back(er);
    apb(1'b0, a, 32'h0);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task idle;
    integer n;
    n = 0;
    while (act !== 1'b0 && n < 400)
    begin
      cyc(1);
      n++;
    end
    if (n >= 400)
    begin
      fail_count++;
      test_done;
    end
  endtask

  // read results popped in order
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      check("prdata", exp_q.pop_front(), prdata);
      check("pslverr", {31'h0, err_q.pop_front()}, {31'h0, pslverr});
    end

  always @(posedge pclk)
    if (act === 1'b1)
      cur <= cur + 1;
    else
    begin
      if (cur != 0)
        last <= cur;
      cur <= 0;
    end

  initial
  begin
    cyc(10);
    presetn <= 1'b1;
    rd(dtc_pkg::RATE_OFF, 32'h2);
    rd(dtc_pkg::THR_ONE_OFF, 32'h55);
    rd(dtc_pkg::THR_TWO_OFF, 32'h55);
    rd(8'h30, 32'h0, 1'b1);
    rd(dtc_pkg::STATUS_OFF, 32'h1);
    wr(dtc_pkg::CFG_OFF, 32'h60);
    cyc(2);
    check("rtype", 32'h1, {31'h0, rtype});
    idle;
    rd(dtc_pkg::LOCAL_OFF, 32'h0);
    rd(dtc_pkg::CFG_OFF, 32'h60);
    wr(dtc_pkg::IRQ_MASK_OFF, 32'h1);
    lv <= 11'($random(seed)) & 11'h1FF;
    rv <= 11'($random(seed)) & 11'h1FF;
    wr(dtc_pkg::ONESHOT_OFF, 32'h0);
    cyc(3);
    rd(dtc_pkg::STATUS_OFF, 32'h1);
    rd(dtc_pkg::LOCAL_OFF, 32'h0);
    idle;
    cyc(2);
    check("busy len", 32'h50, last);
    check("irq", 32'h1, {31'h0, irq});
    rd(dtc_pkg::LOCAL_OFF, {21'h0, lv});
    rd(dtc_pkg::REMOTE_OFF, {21'h0, rv});
    rd(dtc_pkg::STATUS_OFF, 32'h0);
    rd(dtc_pkg::IRQ_STAT_OFF, 32'h1);
    cyc(1);
    check("irq clr", 32'h0, {31'h0, irq});
    old = lv;
    lv <= 11'($random(seed)) & 11'h1FF;
    wr(dtc_pkg::ONESHOT_OFF, 32'h0);
    cyc(10);
    hw_standby_n <= 1'b0;
    idle;
    rd(dtc_pkg::LOCAL_OFF, {21'h0, old});
    wr(dtc_pkg::ONESHOT_OFF, 32'h0);
    cyc(5);
    rd(dtc_pkg::STATUS_OFF, 32'h0);
    hw_standby_n <= 1'b1;
    cyc(4);
    for (i = 0; i < 8; i++)
    begin
      wr(dtc_pkg::RATE_OFF, i);
      rd(dtc_pkg::RATE_OFF, (i > 4) ? 4 : i);
    end
    wr(dtc_pkg::CFG_OFF, 32'h0);
    i = 0;
    while (act !== 1'b1 && i < 500)
    begin
      cyc(1);
      i++;
    end
    idle;
    cyc(2);
    check("legacy len", 32'h28, last);
    rd(dtc_pkg::LOCAL_OFF, {21'h0, lv[10:3], 3'h0});
    wr(dtc_pkg::CFG_OFF, 32'h40);
    idle;
    lv <= 11'h0A0;
    rv <= 11'h050;
    wr(dtc_pkg::IRQ_MASK_OFF, 32'h7);
    wr(dtc_pkg::ONESHOT_OFF, 32'h0);
    cyc(3);
    pce <= 1'b0;
    cyc(20);
    pce <= 1'b1;
    idle;
    cyc(2);
    check("freeze len", 32'h64, last);
    rd(dtc_pkg::IRQ_STAT_OFF, 32'h1);
    wr(dtc_pkg::THR_ONE_OFF, 32'h13);
    wr(dtc_pkg::THR_TWO_OFF, 32'h14);
    cyc(3);
    check("alarm1 oe", 32'h1, {31'h0, a1e});
    check("alarm1 o", 32'h0, {31'h0, a1o});
    check("alarm2 oe", 32'h0, {31'h0, a2e});
    check("alarm2 o", 32'h0, {31'h0, a2o});
    rd(dtc_pkg::IRQ_STAT_OFF, 32'h2);
    wr(dtc_pkg::THR_ONE_OFF, 32'h14);
    cyc(3);
    check("alarm1 off", 32'h0, {31'h0, a1e});
    test_done;
  end
endmodule
